// ===== core/rsc_defines.svh
// rsc_defines.svh: offsets, field positions, reset values and ratios
// of the synthesizer channel divider configuration.
// assumes: included by bare name from core/ files only.
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// register offsets on the serial register port
`define RSC_ADDR_A_CH1 8'h22
`define RSC_ADDR_A_CH2 8'h23
`define RSC_ADDR_A_CH3 8'h24
`define RSC_ADDR_B_CH1 8'h43
`define RSC_ADDR_B_CH2 8'h44
`define RSC_ADDR_B_CH3 8'h45

// reset values
`define RSC_RST_CH1 8'h29
`define RSC_RST_CH2 8'h08
`define RSC_RST_CH3 8'h0A

// writable bits of each register
`define RSC_MASK_CH1 8'h7F
`define RSC_MASK_CHN 8'h1F

// field positions
`define RSC_BAND_HI 6
`define RSC_BAND_LO 5
`define RSC_RDIV_HI 4
`define RSC_RDIV_LO 2
`define RSC_SOFF_HI 1
`define RSC_SOFF_LO 0

// band codes
`define RSC_BAND_315 2'h0
`define RSC_BAND_434 2'h1
`define RSC_BAND_868 2'h2
`define RSC_BAND_RSVD 2'h3

// fixed ratios
`define RSC_RDIV_ZERO_VAL 4'h8
`define RSC_FB_SHIFT 8
`define RSC_QUAD_DIV_SHIFT 2

`endif

// ===== core/rsc_pkg.sv
// rsc_pkg.sv: types shared by the synthesizer configuration block.
// assumes: compiled before any core/ module.
package rsc_pkg;

	// which channel field set drives the divider chain
	typedef enum logic [1:0] {
		RSC_CH1,
		RSC_CH2,
		RSC_CH3
	} rsc_chan_t;

	// one register byte
	typedef logic [7:0] rsc_byte_t;

	// signed modulus offset, -1..+1
	typedef logic signed [1:0] rsc_soff_t;

endpackage : rsc_pkg

// ===== core/rsc_field_decode.sv
// rsc_field_decode.sv: turns one reference divider / modulus offset
// field pair into divider values.
// assumes: fields come from a register, decode is purely combinational.
`timescale 1ns/10ps
`include "rsc_defines.svh"

module rsc_field_decode
	import rsc_pkg::*;
(
	input wire logic [4:0] i_fields,
	output rsc_soff_t o_mod_offset,
	output logic [3:0] o_ref_div
);

	logic [2:0] rdiv_code;
	logic [1:0] soff_code;

	// field split
	assign rdiv_code = i_fields[`RSC_RDIV_HI:`RSC_RDIV_LO];
	assign soff_code = i_fields[`RSC_SOFF_HI:`RSC_SOFF_LO];

	// code 000 means eight, others their own value
	assign o_ref_div = (rdiv_code == 3'h0) ? `RSC_RDIV_ZERO_VAL :
		{1'b0, rdiv_code}; // R02

	// 00 -> +1, 10 -> -1, 01 and 11 -> 0
	always_comb begin
		case (soff_code) // R03
			2'h0: o_mod_offset = 2'sh1;
			2'h2: o_mod_offset = -2'sh1;
			default: o_mod_offset = 2'sh0;
		endcase
	end

endmodule : rsc_field_decode

// ===== core/rsc_synth_cfg.sv
// rsc_synth_cfg.sv: channel divider configuration of the rf synthesizer.
// assumes: a serial port decoder delivers one-cycle byte writes; mode
// and configuration selects are synchronous levels from the mode control.
//
// How it works
// R01: band field bits 6:5 select A: 00 gives 3, 01 gives 2, 10 gives 1.
// R02: reference divider field 4:2: code 000 is eight, others their value.
// R03: modulus offset field 1:0: 00 is +1, 10 is -1, others zero.
// R04: channel 2 fields at 4:2 and 1:0 apply only in polling.
// R05: exactly one channel field set drives the divider chain.
// R06: feedback divides by 256*R+S, reference by R.
// R07: band divider feeds a fixed divide by four for quadrature LO.
// R08: channel 1 set, with band, serves slave and polling operation.
// R09: configs A and B own copies; ch1 resets 0x29, ch2 0x08.
// R10: band code 11 is reserved and keeps the last applied band.
// R11: channel 3 fields at 4:2 and 1:0, polling only, reset 0x0A.
`timescale 1ns/10ps
`include "rsc_defines.svh"

module rsc_synth_cfg
	import rsc_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int FB_W = 12
) (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_reg_wr_en,
	input wire logic [ADDR_W-1:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_self_poll,
	input wire logic i_slave_cfg_b,
	input wire logic i_poll_cfg_b,
	input wire logic [1:0] i_poll_chan,
	output logic [1:0] o_band_code,
	output logic [1:0] o_band_div,
	output logic [3:0] o_rf_post_div,
	output logic [3:0] o_ref_div,
	output rsc_soff_t o_mod_offset,
	output logic [FB_W-1:0] o_fb_div,
	output logic [1:0] o_active_chan,
	output logic o_active_cfg_b
);

	// register byte address of config c, channel k
	function automatic logic [ADDR_W-1:0] addr_of(input int c, input int k);
		logic [7:0] a;
		case ({c[0], k[1:0]})
			3'h0: a = `RSC_ADDR_A_CH1;
			3'h1: a = `RSC_ADDR_A_CH2;
			3'h2: a = `RSC_ADDR_A_CH3;
			3'h4: a = `RSC_ADDR_B_CH1;
			3'h5: a = `RSC_ADDR_B_CH2;
			default: a = `RSC_ADDR_B_CH3;
		endcase
		return ADDR_W'(a);
	endfunction : addr_of

	// polling channel number to channel set, 0 falls back to channel 1
	function automatic rsc_chan_t chan_of(input logic [1:0] n);
		case (n)
			2'h2: return RSC_CH2;
			2'h3: return RSC_CH3;
			default: return RSC_CH1;
		endcase
	endfunction : chan_of

	// band code to RF output divider A
	function automatic logic [1:0] band_to_a(input logic [1:0] code);
		case (code)
			`RSC_BAND_315: return 2'h3;
			`RSC_BAND_434: return 2'h2;
			default: return 2'h1;
		endcase
	endfunction : band_to_a

	rsc_byte_t reg_q [2][3];
	rsc_byte_t reg_d [2][3];
	logic cfg_sel;
	rsc_chan_t chan_sel;
	logic [4:0] ch_fields [3];
	logic [3:0] dec_r [3];
	rsc_soff_t dec_s [3];
	logic [1:0] band_sel;
	logic [1:0] band_d;
	logic [1:0] band_a_d;
	logic [3:0] ref_div_d;
	rsc_soff_t mod_offset_d;

	// register writes, per config copy, reserved bits dropped
	always_comb begin
		reg_d = reg_q;
		for (int c = 0; c < 2; c++) begin
			for (int k = 0; k < 3; k++) begin
				if (i_reg_wr_en && i_reg_addr == addr_of(c, k)) begin // R09
					reg_d[c][k] = i_reg_wdata &
						((k == 0) ? `RSC_MASK_CH1 : `RSC_MASK_CHN);
				end
			end
		end
	end

	// register storage with documented reset values
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int c = 0; c < 2; c++) begin
				reg_q[c][0] <= `RSC_RST_CH1; // R09
				reg_q[c][1] <= `RSC_RST_CH2; // R09
				reg_q[c][2] <= `RSC_RST_CH3; // R11
			end
		end else begin
			reg_q <= reg_d;
		end
	end

	// active config and channel: slave always runs channel 1
	assign cfg_sel = i_self_poll ? i_poll_cfg_b : i_slave_cfg_b;
	assign chan_sel = i_self_poll ? chan_of(i_poll_chan) : RSC_CH1; // R08

	// field decoders for the three channels of the active config
	for (genvar k = 0; k < 3; k++) begin : g_dec
		assign ch_fields[k] = reg_q[cfg_sel][k][4:0]; // R04 R11
		rsc_field_decode u_dec (
			.i_fields(ch_fields[k]),
			.o_mod_offset(dec_s[k]),
			.o_ref_div(dec_r[k])
		);
	end

	// steer one channel set and the band to the divider chain
	always_comb begin
		ref_div_d = dec_r[int'(chan_sel)]; // R05
		mod_offset_d = dec_s[int'(chan_sel)]; // R05
		band_sel = reg_q[cfg_sel][0][`RSC_BAND_HI:`RSC_BAND_LO]; // R08
		band_d = (band_sel == `RSC_BAND_RSVD) ? o_band_code : band_sel; // R10
		band_a_d = band_to_a(band_d); // R01
	end

	// divider chain settings, all registered
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_band_code <= `RSC_BAND_434;
			o_band_div <= 2'h2;
			o_rf_post_div <= 4'h8;
			o_ref_div <= 4'h2;
			o_mod_offset <= 2'sh0;
			o_fb_div <= FB_W'(12'h200);
			o_active_chan <= 2'h1;
			o_active_cfg_b <= 1'b0;
		end else begin
			o_band_code <= band_d; // R10
			o_band_div <= band_a_d; // R01
			o_rf_post_div <= {band_a_d, 2'b00}; // R07
			o_ref_div <= ref_div_d; // R06
			o_mod_offset <= mod_offset_d;
			o_fb_div <= FB_W'({ref_div_d, 8'h00}) +
				FB_W'(signed'(mod_offset_d)); // R06
			o_active_chan <= 2'(int'(chan_sel) + 1);
			o_active_cfg_b <= cfg_sel;
		end
	end

	// checks on decode, steering and hold behaviour
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	a_band_a_map: assert property ( // R01
		o_band_div == 2'(3 - int'(o_band_code)))
		else $error("band divider does not match band code");

	a_rdiv_zero_eight: assert property ( // R02
		ch_fields[int'(chan_sel)][4:2] == 3'h0 |=> o_ref_div == 4'h8)
		else $error("reference code zero not decoded as eight");

	a_soff_minus: assert property ( // R03
		ch_fields[int'(chan_sel)][1:0] == 2'h2 |=> o_mod_offset == -2'sh1)
		else $error("offset code 10 not decoded as minus one");

	a_ch2_poll: assert property ( // R04
		i_self_poll && i_poll_chan == 2'h2 &&
		ch_fields[1][4:2] == 3'h3 |=> o_ref_div == 4'h3 &&
		o_active_chan == 2'h2)
		else $error("channel 2 set not applied in polling");

	a_fb_ratio: assert property ( // R06
		##1 o_fb_div == FB_W'({o_ref_div, 8'h00}) +
		FB_W'(signed'(o_mod_offset)))
		else $error("feedback ratio is not 256R+S");

	a_quad_div: assert property ( // R07
		o_rf_post_div == {o_band_div, 2'b00})
		else $error("post divider not four times band divider");

	a_slave_ch1: assert property ( // R08
		!i_self_poll |=> o_active_chan == 2'h1 &&
		o_active_cfg_b == $past(i_slave_cfg_b))
		else $error("slave operation not on channel 1");

	a_write_reach: assert property ( // R09
		(i_reg_wr_en && i_reg_addr == ADDR_W'(`RSC_ADDR_B_CH1) &&
		i_reg_wdata[4:2] == 3'h5 && !i_self_poll && i_slave_cfg_b)
		##1 (!i_reg_wr_en && !i_self_poll && i_slave_cfg_b)
		|=> o_ref_div == 4'h5)
		else $error("config B channel 1 write did not reach divider");

	a_band_hold: assert property ( // R10
		band_sel == `RSC_BAND_RSVD |=> $stable(o_band_code))
		else $error("reserved band code changed the band");

	a_ch3_poll: assert property ( // R11
		i_self_poll && i_poll_chan == 2'h3 &&
		ch_fields[2][1:0] == 2'h1 |=> o_mod_offset == 2'sh0 &&
		o_active_chan == 2'h3)
		else $error("channel 3 set not applied in polling");

	c_band_rsvd: cover property (band_sel == `RSC_BAND_RSVD);
	c_poll_ch3: cover property (i_self_poll && i_poll_chan == 2'h3);
	c_slave_cfg_b: cover property (!i_self_poll && i_slave_cfg_b ##2
		o_active_cfg_b);
	c_band_868: cover property (o_band_div == 2'h1);

endmodule : rsc_synth_cfg

// ===== tb/tb_rsc_synth_cfg.sv
// tb_rsc_synth_cfg.sv: self-checking bench of the synthesizer divider config.
// assumes: core/ package, header and modules compiled first.
`timescale 1ns/10ps
module tb_rsc_synth_cfg;
import rsc_pkg::*;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

typedef logic [28:0] rsc_view_t;
localparam logic [7:0] AMAP [7] = '{8'h22, 8'h23, 8'h24, 8'h43, 8'h44, 8'h45,
	8'h25};
logic i_core_clk = 1'b0;
logic i_reset_n = 1'b0;
logic i_reg_wr_en = 1'b0;
logic [7:0] i_reg_addr = 8'h00;
logic [7:0] i_reg_wdata = 8'h00;
logic i_self_poll = 1'b0;
logic i_slave_cfg_b = 1'b0;
logic i_poll_cfg_b = 1'b0;
logic [1:0] i_poll_chan = 2'h0;
logic [1:0] o_band_code, o_band_div, o_active_chan;
logic [3:0] o_rf_post_div, o_ref_div;
rsc_soff_t o_mod_offset;
logic [11:0] o_fb_div;
logic o_active_cfg_b;
logic [7:0] regs [2][3];
logic [1:0] band_q = 2'h1;
logic [31:0] seed = 32'hB1BFB9A5;
rsc_view_t exp_q [$];
int error_cnt = 0;
int checks = 0;

rsc_synth_cfg dut_u (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
	.i_reg_wr_en(i_reg_wr_en), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .i_self_poll(i_self_poll),
	.i_slave_cfg_b(i_slave_cfg_b), .i_poll_cfg_b(i_poll_cfg_b),
	.i_poll_chan(i_poll_chan), .o_band_code(o_band_code),
	.o_band_div(o_band_div), .o_rf_post_div(o_rf_post_div),
	.o_ref_div(o_ref_div), .o_mod_offset(o_mod_offset), .o_fb_div(o_fb_div),
	.o_active_chan(o_active_chan), .o_active_cfg_b(o_active_cfg_b));

// 50 MHz clock
initial begin
	forever #10 i_core_clk = ~i_core_clk;
end

// next pseudo-random word
function automatic logic [31:0] lfsr(input logic [31:0] s);
	return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction : lfsr

// one-cycle byte write, mirrored into the reference copies
task automatic wr(input logic [7:0] a, input logic [7:0] d);
	@(posedge i_core_clk);
	i_reg_wr_en <= 1'b1;
	i_reg_addr <= a;
	i_reg_wdata <= d;
	for (int k = 0; k < 6; k++) begin
		if (AMAP[k] == a) regs[k / 3][k % 3] = d;
	end
	@(posedge i_core_clk);
	i_reg_wr_en <= 1'b0;
endtask : wr

// mode and select levels
task automatic sel(input logic p, input logic sb, input logic pb,
	input logic [1:0] ch);
	@(posedge i_core_clk);
	i_self_poll <= p;
	i_slave_cfg_b <= sb;
	i_poll_cfg_b <= pb;
	i_poll_chan <= ch;
endtask : sel

// let the effect land, then note the expected outputs
task automatic chk();
	int ac, cb, r;
	logic [4:0] f;
	logic [1:0] s, a;
	repeat (3) @(posedge i_core_clk);
	ac = (i_self_poll && i_poll_chan != 2'h0) ? i_poll_chan : 1;
	cb = i_self_poll ? i_poll_cfg_b : i_slave_cfg_b;
	if (regs[cb][0][6:5] != 2'h3) band_q = regs[cb][0][6:5];
	a = (band_q == 2'h0) ? 2'h3 : (band_q == 2'h1) ? 2'h2 : 2'h1;
	f = regs[cb][ac - 1][4:0];
	r = (f[4:2] == 3'h0) ? 8 : f[4:2];
	s = (f[1:0] == 2'h0) ? 2'h1 : (f[1:0] == 2'h2) ? 2'h3 : 2'h0;
	exp_q.push_back({band_q, a, {a, 2'h0}, r[3:0], s,
		12'(256 * r + $signed(s)), ac[1:0], cb[0]});
endtask : chk

task automatic end_of_test();
	$display("comparisons %0d mismatches %0d", checks, error_cnt);
	if (error_cnt == 0 && checks > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask : end_of_test

// watcher: each noted result is compared in a settled half cycle
always @(negedge i_core_clk) begin
	rsc_view_t got;
	rsc_view_t want;
	got = {o_band_code, o_band_div, o_rf_post_div, o_ref_div, o_mod_offset,
		o_fb_div, o_active_chan, o_active_cfg_b};
	if (exp_q.size() > 0) begin
		want = exp_q.pop_front();
		`CHK(got[28:27], want[28:27])
		`CHK(got[26:25], want[26:25])
		`CHK(got[24:21], want[24:21])
		`CHK(got[20:17], want[20:17])
		`CHK(got[16:15], want[16:15])
		`CHK(got[14:3], want[14:3])
		`CHK(got[2:1], want[2:1])
		`CHK(got[0], want[0])
	end
end

// hang guard
initial begin
	#2000000;
	error_cnt++;
	end_of_test();
end

// main sequence
initial begin
	for (int c = 0; c < 2; c++) begin
		regs[c][0] = 8'h29;
		regs[c][1] = 8'h08;
		regs[c][2] = 8'h0A;
	end
	repeat (3) @(posedge i_core_clk);
	i_reset_n <= 1'b1;
	chk();
	$display("test reset values done");
	// every band, divider and offset code in slave config A
	for (int i = 0; i < 128; i++) begin
		wr(8'h22, i[7:0]);
		chk();
	end
	$display("test all codes done");
	// polling: every channel of both configs, config A band code reserved so last band kept
	for (int i = 0; i < 8; i++) begin
		sel(1'b1, 1'b0, i[2], i[1:0]);
		chk();
	end
	$display("test polling sweep done");
	// directed: slave config B write, then channel 2 and 3 polling decodes
	sel(1'b0, 1'b1, 1'b0, 2'h0);
	chk();
	wr(8'h43, 8'h35);
	chk();
	wr(8'h23, 8'h0D);
	wr(8'h24, 8'h0D);
	sel(1'b1, 1'b0, 1'b0, 2'h2);
	chk();
	sel(1'b1, 1'b0, 1'b0, 2'h3);
	chk();
	$display("test directed cases done");
	// random writes, unmapped address and select changes
	for (int i = 0; i < 300; i++) begin
		seed = lfsr(seed);
		if (seed[0])
			wr(AMAP[seed[3:1] % 7], seed[15:8]);
		else
			sel(seed[8], seed[9], seed[10], seed[12:11]);
		chk();
	end
	$display("test random mix done");
	repeat (4) @(posedge i_core_clk);
	end_of_test();
end

endmodule : tb_rsc_synth_cfg
